// *** src/tpg_pattern_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module tpg_pattern_gen
  import tpg_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic              reg_wr_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output var  logic [7:0]        reg_rdata,
  // line timing pin
  input  wire logic              line_clamp_pulse_input,
  // converted samples
  input  wire logic [CODE_W-1:0] adc_ch1,
  input  wire logic [CODE_W-1:0] adc_ch2,
  // serializer feed
  output var  logic [CODE_W-1:0] lvds_ch1_data,
  output var  logic [CODE_W-1:0] lvds_ch2_data
);

  tpg_ctrl_s         ctrl_reg;
  logic [7:0]        pitch_reg;
  logic [7:0]        step_reg;
  logic [3:0]        chan_delay_reg;
  logic [7:0]        value_hi_reg;
  logic [5:0]        value_lo_reg;
  logic [15:0]       start_reg;
  logic [15:0]       width_reg;
  logic [7:0]        rdata_reg;
  logic [2:0]        clamp_sync_reg;
  logic              clamp_edge;
  logic              seen_reg;
  logic              line_live_reg;
  logic [15:0]       pix_cnt_reg;
  logic              in_region;
  logic              any_src;
  logic [CODE_W-1:0] value_code;
  logic [CODE_W-1:0] low_code;
  logic [7:0]        h_cnt_reg;
  logic [CODE_W-1:0] h_code_reg;
  logic              h_phase_reg;
  logic              h_wrap;
  logic              lvds_syn_reg;
  logic              lvds_asy_reg;
  logic [CODE_W-1:0] lfsr_reg;
  logic [CODE_W-1:0] adc_in  [NUM_CH];
  logic [CODE_W-1:0] out_reg [NUM_CH];

  // pattern value is high byte over low six bits
  assign value_code = {value_hi_reg, value_lo_reg};
  assign low_code   = {6'h00, step_reg};
  assign adc_in[0]  = adc_ch1;
  assign adc_in[1]  = adc_ch2;
  assign lvds_ch1_data = out_reg[0];
  assign lvds_ch2_data = out_reg[1];
  assign reg_rdata     = rdata_reg;

  // register writes; every register starts at the zero baseline
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg       <= tpg_ctrl_s'(BASELINE_BYTE);
      pitch_reg      <= BASELINE_BYTE;
      step_reg       <= BASELINE_BYTE;
      chan_delay_reg <= BASELINE_BYTE[3:0];
      value_hi_reg   <= BASELINE_BYTE;
      value_lo_reg   <= BASELINE_BYTE[VALUE_LO_W-1:0];
      start_reg      <= BASELINE_WORD;
      width_reg      <= BASELINE_WORD;
    end else if (reg_wr_en) begin
      case (reg_addr)
        ADDR_START_HI:   start_reg[15:8]  <= reg_wdata;
        ADDR_START_LO:   start_reg[7:0]   <= reg_wdata;
        ADDR_WIDTH_HI:   width_reg[15:8]  <= reg_wdata;
        ADDR_WIDTH_LO:   width_reg[7:0]   <= reg_wdata;
        ADDR_CONTROL:    ctrl_reg         <= tpg_ctrl_s'(reg_wdata);
        ADDR_PITCH:      pitch_reg        <= reg_wdata;
        ADDR_STEP:       step_reg         <= reg_wdata;
        ADDR_CHAN_DELAY: chan_delay_reg   <= reg_wdata[3:0];
        ADDR_VALUE_HI:   value_hi_reg     <= reg_wdata;
        ADDR_VALUE_LO:   value_lo_reg     <= reg_wdata[VALUE_LO_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // readback, one cycle behind the address; unused bits and addresses read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= BASELINE_BYTE;
    end else begin
      case (reg_addr)
        ADDR_START_HI:   rdata_reg <= start_reg[15:8];
        ADDR_START_LO:   rdata_reg <= start_reg[7:0];
        ADDR_WIDTH_HI:   rdata_reg <= width_reg[15:8];
        ADDR_WIDTH_LO:   rdata_reg <= width_reg[7:0];
        ADDR_CONTROL:    rdata_reg <= ctrl_reg;
        ADDR_PITCH:      rdata_reg <= pitch_reg;
        ADDR_STEP:       rdata_reg <= step_reg;
        ADDR_CHAN_DELAY: rdata_reg <= {4'h0, chan_delay_reg};
        ADDR_VALUE_HI:   rdata_reg <= value_hi_reg;
        ADDR_VALUE_LO:   rdata_reg <= {2'h0, value_lo_reg};
        default:         rdata_reg <= BASELINE_BYTE;
      endcase
    end
  end

  // clamp pin crosses in through two flops; the third only serves edge detect
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clamp_sync_reg <= 3'h0;
    end else begin
      clamp_sync_reg <= {clamp_sync_reg[1:0], line_clamp_pulse_input};
    end
  end
  assign clamp_edge = clamp_sync_reg[1] & ~clamp_sync_reg[2];

  assign any_src = ctrl_reg.prbs_en | ctrl_reg.pat_en;

  // pixel position since the last clamp leading edge, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pix_cnt_reg <= 16'h0000;
      seen_reg    <= 1'b0;
    end else if (clamp_edge) begin
      pix_cnt_reg <= 16'h0000;
      seen_reg    <= 1'b1;
    end else if (pix_cnt_reg != 16'hFFFF) begin
      pix_cnt_reg <= pix_cnt_reg + 16'h0001;
    end
  end

  // valid region is [start, start + width); nothing before the first clamp
  assign in_region = seen_reg & (pix_cnt_reg >= start_reg) &
                     ({1'b0, pix_cnt_reg} < ({1'b0, start_reg} + {1'b0, width_reg}));

  // line tracking restarts whenever every source is switched off
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !any_src) begin
      line_live_reg <= 1'b0;
    end else if (clamp_edge) begin
      line_live_reg <= 1'b1;
    end
  end

  // pitch of zero behaves as one so the pattern never stalls
  assign h_wrap = ({1'b0, h_cnt_reg} + 9'h001) >= {1'b0, pitch_reg};

  // horizontal step state, shared by both channels
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clamp_edge) begin
      h_cnt_reg   <= 8'h00;
      h_code_reg  <= value_code;
      h_phase_reg <= 1'b1;
    end else if (in_region) begin
      if (h_wrap) begin
        h_cnt_reg   <= 8'h00;
        h_code_reg  <= h_code_reg + low_code;
        h_phase_reg <= ~h_phase_reg;
      end else begin
        h_cnt_reg <= h_cnt_reg + 8'h01;
      end
    end
  end

  // lvds test phase: one copy realigned at each clamp edge, one free running
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lvds_syn_reg <= 1'b0;
      lvds_asy_reg <= 1'b0;
    end else begin
      lvds_syn_reg <= clamp_edge ? 1'b0 : ~lvds_syn_reg;
      lvds_asy_reg <= ~lvds_asy_reg;
    end
  end

  // lfsr: xnor feedback so an all-zero seed still runs; load beats advance
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lfsr_reg <= 14'h0000;
    end else if (ctrl_reg.seed_load && clamp_edge) begin
      lfsr_reg <= value_code;
    end else if (ctrl_reg.prbs_en && in_region) begin
      lfsr_reg <= {lfsr_reg[CODE_W-2:0], ~^(lfsr_reg & LFSR_TAPS)};
    end
  end

  // per channel line state and output mux
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [3:0]        dly_cnt_reg;
    logic [7:0]        v_cnt_reg;
    logic [CODE_W-1:0] v_code_reg;
    logic              v_phase_reg;
    logic [3:0]        dly_lines;
    logic              v_wrap;
    logic              routed;
    logic              use_pat;
    logic [CODE_W-1:0] pat_code;

    // only channel 2 lags; its line state holds at line zero meanwhile
    assign dly_lines = (c == 0) ? 4'h0 : chan_delay_reg;
    assign v_wrap    = ({1'b0, v_cnt_reg} + 9'h001) >= {1'b0, pitch_reg};

    always_ff @(posedge ref_clk) begin
      if (sys_rst || !any_src) begin
        dly_cnt_reg <= 4'h0;
        v_cnt_reg   <= 8'h00;
        v_code_reg  <= value_code;
        v_phase_reg <= 1'b1;
      end else if (clamp_edge && line_live_reg) begin
        if (dly_cnt_reg < dly_lines) begin
          dly_cnt_reg <= dly_cnt_reg + 4'h1;
        end else if (v_wrap) begin
          v_cnt_reg   <= 8'h00;
          v_code_reg  <= v_code_reg + low_code;
          v_phase_reg <= ~v_phase_reg;
        end else begin
          v_cnt_reg <= v_cnt_reg + 8'h01;
        end
      end
    end

    // unused route code leaves both channels on converted data
    assign routed = (ctrl_reg.route == ROUTE_BOTH) ||
                    ((c == 0) && (ctrl_reg.route == ROUTE_CH1)) ||
                    ((c == 1) && (ctrl_reg.route == ROUTE_CH2));

    always_comb begin
      pat_code = value_code;
      case (ctrl_reg.mode)
        MODE_FIXED:    pat_code = value_code;
        MODE_HGRAD:    pat_code = h_code_reg;
        MODE_VGRAD:    pat_code = v_code_reg;
        MODE_LATTICE:  pat_code = (h_phase_reg ^ v_phase_reg) ? value_code : low_code;
        MODE_STRIPE:   pat_code = h_phase_reg ? value_code : low_code;
        MODE_LVDS_SYN: pat_code = lvds_syn_reg ? ~value_code : value_code;
        MODE_LVDS_ASY: pat_code = lvds_asy_reg ? ~value_code : value_code;
        default:       pat_code = value_code;
      endcase
    end

    // prbs wins over the pattern switch; mode 111 drives no pattern code but still counts as a source
    assign use_pat = in_region & routed &
                     (ctrl_reg.prbs_en |
                      (ctrl_reg.pat_en & (ctrl_reg.mode != MODE_UNUSED)));

    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        out_reg[c] <= 14'h0000;
      end else if (use_pat) begin
        out_reg[c] <= ctrl_reg.prbs_en ? lfsr_reg : pat_code;
      end else begin
        out_reg[c] <= adc_in[c];
      end
    end
  end

endmodule
`default_nettype wire

// *** src/tpg_pkg.sv ***
package tpg_pkg;

  localparam int CODE_W = 14;
  localparam int ADDR_W = 6;
  localparam int VALUE_LO_W = 6;

  // register indices as the serial port addresses them
  localparam logic [5:0] ADDR_START_HI   = 6'h30;
  localparam logic [5:0] ADDR_START_LO   = 6'h31;
  localparam logic [5:0] ADDR_WIDTH_HI   = 6'h32;
  localparam logic [5:0] ADDR_WIDTH_LO   = 6'h33;
  localparam logic [5:0] ADDR_CONTROL    = 6'h34;
  localparam logic [5:0] ADDR_PITCH      = 6'h35;
  localparam logic [5:0] ADDR_STEP       = 6'h36;
  localparam logic [5:0] ADDR_CHAN_DELAY = 6'h37;
  localparam logic [5:0] ADDR_VALUE_HI   = 6'h38;
  localparam logic [5:0] ADDR_VALUE_LO   = 6'h39;

  // values after reset
  localparam logic [7:0]  BASELINE_BYTE = 8'h00;
  localparam logic [15:0] BASELINE_WORD = 16'h0000;

  // lfsr taps for x^14 + x^13 + x^12 + x^2 + 1, xnor feedback
  localparam logic [CODE_W-1:0] LFSR_TAPS = 14'h3802;

  typedef enum logic [2:0] {
    MODE_FIXED    = 3'b000,
    MODE_HGRAD    = 3'b001,
    MODE_VGRAD    = 3'b010,
    MODE_LATTICE  = 3'b011,
    MODE_STRIPE   = 3'b100,
    MODE_LVDS_SYN = 3'b101,
    MODE_LVDS_ASY = 3'b110,
    MODE_UNUSED   = 3'b111
  } tpg_mode_e;

  typedef enum logic [1:0] {
    ROUTE_BOTH   = 2'b00,
    ROUTE_CH1    = 2'b01,
    ROUTE_CH2    = 2'b10,
    ROUTE_UNUSED = 2'b11
  } tpg_route_e;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       pat_en;
    tpg_mode_e  mode;
    logic       prbs_en;
    logic       seed_load;
    tpg_route_e route;
  } tpg_ctrl_s;

endpackage

// *** tb/tpg_rx_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tpg_rx_model
  import tpg_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // codes from the generator
  input  wire logic [CODE_W-1:0] lvds_ch1_data,
  input  wire logic [CODE_W-1:0] lvds_ch2_data,
  // captured words
  output var  logic [CODE_W-1:0] rx_ch1,
  output var  logic [CODE_W-1:0] rx_ch2
);
  // one word per pixel, no back-pressure, so it lags the wire by a cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_ch1 <= 14'h0000;
      rx_ch2 <= 14'h0000;
    end else begin
      rx_ch1 <= lvds_ch1_data;
      rx_ch2 <= lvds_ch2_data;
    end
  end
endmodule
`default_nettype wire

// *** tb/tpg_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module tpg_checker
  import tpg_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  // register port
  input wire logic              reg_wr_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  // pixel stream
  input wire logic              line_clamp_pulse_input,
  input wire logic [CODE_W-1:0] adc_ch1,
  input wire logic [CODE_W-1:0] adc_ch2,
  input wire logic [CODE_W-1:0] lvds_ch1_data,
  input wire logic [CODE_W-1:0] lvds_ch2_data
);
  tpg_ctrl_s         ctl_reg;
  logic [CODE_W-1:0] val_reg;
  logic [15:0]       sta_reg;
  logic [15:0]       wid_reg;
  logic              pat;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  assign pat = ctl_reg.pat_en && !ctl_reg.prbs_en;
  // shadow of the settings, so outputs can be judged against them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl_reg <= tpg_ctrl_s'(8'h00);
      val_reg <= 14'h0000;
      sta_reg <= 16'h0000;
      wid_reg <= 16'h0000;
    end else if (reg_wr_en) begin
      case (reg_addr)
        ADDR_CONTROL:  ctl_reg <= tpg_ctrl_s'(reg_wdata);
        ADDR_VALUE_HI: val_reg[13:6] <= reg_wdata;
        ADDR_VALUE_LO: val_reg[5:0] <= reg_wdata[5:0];
        ADDR_START_HI: sta_reg[15:8] <= reg_wdata;
        ADDR_START_LO: sta_reg[7:0] <= reg_wdata;
        ADDR_WIDTH_HI: wid_reg[15:8] <= reg_wdata;
        ADDR_WIDTH_LO: wid_reg[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end
  sequence s_rise;
    !line_clamp_pulse_input ##1 line_clamp_pulse_input;
  endsequence
  sequence s_wr_rd(logic [5:0] a);
    reg_wr_en && reg_addr == a ##1 !reg_wr_en && reg_addr == a;
  endsequence
  // the edge right after reset still sees the cleared output register
  property p_pass;
    !$past(sys_rst) && !(ctl_reg.pat_en || ctl_reg.prbs_en) |->
      lvds_ch1_data == $past(adc_ch1) && lvds_ch2_data == $past(adc_ch2);
  endproperty
  a_pass: assert property (p_pass) else $error("sample not passed");
  property p_fixed;
    pat && ctl_reg.mode == MODE_FIXED && ctl_reg.route[1] == 1'b0 |->
      lvds_ch1_data == val_reg || lvds_ch1_data == $past(adc_ch1);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed code wrong");
  property p_ch1only;
    pat && ctl_reg.route == ROUTE_CH1 |-> lvds_ch2_data == $past(adc_ch2);
  endproperty
  a_ch1only: assert property (p_ch1only) else $error("ch2 not passed");
  property p_ch2only;
    pat && ctl_reg.route == ROUTE_CH2 |-> lvds_ch1_data == $past(adc_ch1);
  endproperty
  a_ch2only: assert property (p_ch2only) else $error("ch1 not passed");
  property p_unused;
    pat && ctl_reg.mode == MODE_UNUSED |->
      lvds_ch1_data == $past(adc_ch1) && lvds_ch2_data == $past(adc_ch2);
  endproperty
  a_unused: assert property (p_unused) else $error("unused mode drove code");
  // region starts one pixel after the clamp when start is one
  property p_line;
    s_rise ##0 (pat && ctl_reg.mode == MODE_FIXED && ctl_reg.route == ROUTE_BOTH
      && sta_reg == 16'h0001 && wid_reg != 16'h0000) ##0 (!reg_wr_en)[*5] |->
      lvds_ch1_data == $past(adc_ch1) ##1 lvds_ch1_data == val_reg;
  endproperty
  a_line: assert property (p_line) else $error("region start wrong");
  property p_hi_rb;
    s_wr_rd(ADDR_VALUE_HI) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_hi_rb: assert property (p_hi_rb) else $error("value high readback");
  property p_lo_rb;
    s_wr_rd(ADDR_VALUE_LO) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3F);
  endproperty
  a_lo_rb: assert property (p_lo_rb) else $error("value low readback");
endmodule
bind tpg_pattern_gen tpg_checker u_chk (.ref_clk, .sys_rst, .reg_wr_en, .reg_addr,
  .reg_wdata, .reg_rdata, .line_clamp_pulse_input, .adc_ch1, .adc_ch2, .lvds_ch1_data,
  .lvds_ch2_data);
`default_nettype wire

// *** tb/tpg_pattern_gen_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tpg_pattern_gen_tb
  import tpg_pkg::*;
;
  localparam logic [13:0] A1 = 14'h0AAA;
  localparam logic [13:0] A2 = 14'h0555;
  localparam logic [13:0] V  = 14'h1234;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reg_wr_en = 1'b0;
  logic [5:0]        reg_addr = 6'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic [7:0]        reg_rdata;
  logic              line_clamp_pulse_input = 1'b0;
  logic [CODE_W-1:0] adc_ch1 = A1;
  logic [CODE_W-1:0] adc_ch2 = A2;
  logic [CODE_W-1:0] lvds_ch1_data, lvds_ch2_data, rx_ch1, rx_ch2;
  logic [CODE_W-1:0] c1[8], c2[8];
  logic              ph[8];
  int                cyc = 0;
  int                fails = 0;
  int                check_count = 0;
  always #25 ref_clk = ~ref_clk;
  // edges since reset release; the free running test phase flips on every one
  always @(posedge ref_clk) cyc <= sys_rst ? 0 : cyc + 1;
  tpg_pattern_gen u_dut (.ref_clk, .sys_rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata,
    .line_clamp_pulse_input, .adc_ch1, .adc_ch2, .lvds_ch1_data, .lvds_ch2_data);
  tpg_rx_model u_rx (.ref_clk, .sys_rst, .lvds_ch1_data, .lvds_ch2_data, .rx_ch1, .rx_ch2);
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // extra idle cycle keeps the strobe from being set twice in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step();
    reg_wr_en = 1'b0;
    step();
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_addr = a;
    step();
    chk("reg_rdata", {6'h00, reg_rdata}, {6'h00, e});
  endtask
  // clamp high two cycles; receiver shows pixel 0 five edges after the rise
  task automatic line();
    line_clamp_pulse_input = 1'b1;
    repeat (2) step();
    line_clamp_pulse_input = 1'b0;
    repeat (3) step();
    for (int k = 0; k < 8; k++) begin
      c1[k] = rx_ch1;
      c2[k] = rx_ch2;
      ph[k] = cyc[0];
      step();
    end
  endtask
  // region is pixels 1..4 with pitch 2 and step 3
  task automatic go(input logic [7:0] c);
    logic [13:0] p;
    logic        in;
    int          j;
    wr(ADDR_CONTROL, c);
    line();
    for (int k = 0; k < 8; k++) begin
      j = k - 1;
      in = (k >= 1) && (k <= 4) && c[7];
      case (c[6:4])
        MODE_FIXED:    p = V;
        MODE_HGRAD:    p = V + 14'(3 * (j / 2));
        MODE_STRIPE:   p = (j < 2) ? V : 14'h0003;
        MODE_LVDS_SYN: p = k[0] ? ~V : V;
        MODE_LVDS_ASY: p = ph[k] ? ~V : V;
        MODE_LATTICE:  p = (j < 2) ? 14'h0003 : V;
        default: begin
          p = A1;
          in = 1'b0;
        end
      endcase
      // prbs wins over the switch; without seed load it carries on from four advances
      if (c[3]) begin
        p = V;
        for (int s = 0; s < j + (c[2] ? 0 : 4); s++) begin
          p = {p[12:0], ~(p[13] ^ p[12] ^ p[11] ^ p[1])};
        end
        in = (k >= 1) && (k <= 4);
      end
      chk("lvds_ch1", c1[k], (in && c[1:0] < 2'b10) ? p : A1);
      chk("lvds_ch2", c2[k], (in && c[1:0] != 2'b01 && c[1:0] != 2'b11) ? p : A2);
    end
  endtask
  initial begin
    repeat (16) step();
    sys_rst = 1'b0;
    rd(ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 10; i++) wr(ADDR_START_HI + 6'(i), 8'h00);
    wr(ADDR_CHAN_DELAY, 8'hFF);
    rd(ADDR_CHAN_DELAY, 8'h0F);
    wr(ADDR_VALUE_LO, 8'hFF);
    rd(ADDR_VALUE_LO, 8'h3F);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(ADDR_VALUE_HI, 8'h48);
    rd(ADDR_VALUE_HI, 8'h48);
    wr(ADDR_VALUE_LO, 8'h34);
    wr(ADDR_START_LO, 8'h01);
    wr(ADDR_WIDTH_LO, 8'h04);
    wr(ADDR_PITCH, 8'h02);
    wr(ADDR_STEP, 8'h03);
    go(8'h00);
    go(8'hB0);
    for (int r = 0; r < 4; r++) go({6'h20, r[1:0]});
    go(8'hF0);
    go(8'h90);
    go(8'hC0);
    go(8'hD0);
    go(8'hE0);
    go(8'h8C);
    go(8'h88);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CHAN_DELAY, 8'h01);
    wr(ADDR_CONTROL, 8'hA0);
    for (int n = 0; n < 4; n++) begin
      line();
      chk("vgrad_ch1", c1[1], (n > 1) ? V + 14'h0003 : V);
      chk("vgrad_ch2", c2[1], (n > 2) ? V + 14'h0003 : V);
    end
    // converted samples must come through exactly one pixel later
    wr(ADDR_CONTROL, 8'h00);
    adc_ch1 = A2;
    adc_ch2 = A1;
    step();
    chk("lvds_ch1", lvds_ch1_data, A2);
    chk("lvds_ch2", lvds_ch2_data, A1);
    step();
    chk("rx_ch1", rx_ch1, A2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
